/* File: monitor_port_pkg.sv */
// Package for the monitor-port transmit-only streaming block.
// Assumes a single 200 MHz system clock and sampled external pins.
`default_nettype none

package monitor_port_pkg;

  // ==========================================================================
  // Array geometry
  localparam int ARRAY_DEPTH     = 128;
  localparam int ADDR_W          = 7;
  localparam int DATA_W          = 8;

  // ==========================================================================
  // Framing
  localparam int BITS_PER_FRAME  = 9;
  localparam int SYNC_CYCLES     = 9;
  localparam logic [3:0] NULL_BIT_IDX = 4'h8;
  localparam logic [ADDR_W-1:0] START_ADDR_RESET = 7'h00;

  // ==========================================================================
  // Mode states, one-hot
  typedef enum logic [2:0] {
    ST_SYNC  = 3'b001,
    ST_XMIT  = 3'b010,
    ST_BIDIR = 3'b100
  } port_mode_e;

  // Data line as two signals
  typedef struct packed {
    logic out;
    logic oe;
  } line_drive_s;

  // Array write port
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } array_write_s;

endpackage : monitor_port_pkg

`default_nettype wire

/* File: pin_sync.sv */
// Two-flop synchroniser with one-cycle edge pulses, for a pin input.
// Assumes the pin is asynchronous to clk_in; reset loads RESET_LEVEL, high (idle) by default.
`default_nettype none
`timescale 1ns/1ps

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Pin and sampled views
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
      prev_reg <= RESET_LEVEL;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~prev_reg;
  assign fall_out  = ~sync_reg & prev_reg;

endmodule : pin_sync

`default_nettype wire

/* File: monitor_port_tx.sv */
// Monitor-link port logic: power-up transmit-only streaming of the array,
// and the one-way switch into the bidirectional mode.
// Assumes resetn_in stands for power-on; both clocks come from the host pins.
//
// Behaviour
// (RQ1) After reset the port streams the array, not addressed transactions.
// (RQ2) Each mode has its own clock pin; both share one data line.
// (RQ3) Falling edge on bidir clock switches the port to bidirectional mode.
// (RQ4) Bidirectional mode is left only by reset (power cycle).
// (RQ5) Host holds bidir clock high to stay in transmit-only mode.
// (RQ6) Each byte is eight data bits then a null bit: nine clocks.
// (RQ7) A new bit appears after each rising edge of transmit clock.
// (RQ8) Bits go most significant first.
// (RQ9) Bytes ascend through the array and wrap to zero without a gap.
// (RQ10) Host gives nine transmit clocks after power-up for synchronisation.
// (RQ11) Data line stays released during those nine clocks.
// (RQ12) Tenth rising edge drives the first bit, a byte's MSB.
// (RQ13) Starting byte address after power-up is not defined.
// (RQ14) In bidirectional mode transmit clock level is only a write enable.
// (RQ15) Data line released during each null bit.
`default_nettype none
`timescale 1ns/1ps

module monitor_port_tx
  import monitor_port_pkg::*;
#(
  parameter int DEPTH  = monitor_port_pkg::ARRAY_DEPTH,
  parameter int AW     = monitor_port_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                               clk_in,
  input  wire logic                               resetn_in,
  // Host pins, asynchronous
  input  wire logic                               tx_only_clock_write_protect_in,
  input  wire logic                               bidir_mode_clock_in,
  input  wire logic                               monitor_data_line_in,
  // Data line drive
  output logic                                    monitor_data_line_out,
  output logic                                    monitor_data_line_oe_out,
  // Array write port, filled by the bidirectional engine or loader
  input  wire monitor_port_pkg::array_write_s     array_write_in,
  // Mode and status
  output logic                                    bidir_mode_out,
  output logic                                    write_enable_out,
  output logic [monitor_port_pkg::ADDR_W-1:0]     byte_addr_out
);

  import monitor_port_pkg::*;

  // Address pointer must cover every array location exactly
  if (DEPTH != (1 << AW) || AW != ADDR_W) begin : g_bad_size
    $error("monitor_port_tx: DEPTH must equal 2**AW and AW must match package");
  end

  // ==========================================================================
  // Pin synchronisers
  logic vclk_level;
  logic vclk_rise;
  logic bidir_mode_clock_level;
  logic bidir_mode_clock_fall;

  pin_sync #(.RESET_LEVEL(1'b0)) u_vclk_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .pin_in    (tx_only_clock_write_protect_in),
    .level_out (vclk_level),
    .rise_out  (vclk_rise),
    .fall_out  ()
  );

  // Reset level high so an idle-high clock gives no false edge at release
  pin_sync #(.RESET_LEVEL(1'b1)) u_bidir_mode_clock_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .pin_in    (bidir_mode_clock_in),
    .level_out (bidir_mode_clock_level),
    .rise_out  (),
    .fall_out  (bidir_mode_clock_fall)
  );

  // ==========================================================================
  // Array storage
  logic [DATA_W-1:0] array_mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (array_write_in.en) begin
      array_mem[array_write_in.addr] <= array_write_in.data;
    end
  end

  // ==========================================================================
  // State
  port_mode_e        mode_reg;
  port_mode_e        mode_next;
  logic [3:0]        count_reg;
  logic [3:0]        count_next;
  logic [AW-1:0]     addr_reg;
  logic [AW-1:0]     addr_next;
  logic              data_out_reg;
  logic              data_out_next;
  logic              data_oe_reg;
  logic              data_oe_next;
  logic              wen_reg;

  // ==========================================================================
  // Decode
  // Count holds nine after the sync rises; the next rise is the tenth
  wire               last_sync   = (count_reg == 4'(SYNC_CYCLES));
  wire               last_bit    = (count_reg == NULL_BIT_IDX);
  wire  [3:0]        bit_next    = last_bit ? 4'h0 : count_reg + 4'h1;
  wire  [AW-1:0]     addr_inc    = addr_reg + {{(AW-1){1'b0}}, 1'b1};          // RQ9
  wire  [DATA_W-1:0] cur_byte    = array_mem[addr_reg];
  wire  [DATA_W-1:0] nxt_byte    = array_mem[addr_inc];
  // Bit index within the byte, MSB first
  wire  [2:0]        msb_sel     = 3'(7 - 3'(bit_next));                      // RQ8
  wire               go_bidir    = bidir_mode_clock_fall;                                  // RQ3 RQ5

  always_comb begin
    mode_next     = mode_reg;
    count_next    = count_reg;
    addr_next     = addr_reg;
    data_out_next = data_out_reg;
    data_oe_next  = data_oe_reg;
    case (mode_reg)
      ST_SYNC: begin
        data_oe_next  = 1'b0;                                                  // RQ11
        data_out_next = 1'b1;
        if (go_bidir) begin
          mode_next = ST_BIDIR;                                                // RQ3
        end else if (vclk_rise) begin                                          // RQ10
          if (last_sync) begin
            // Tenth edge: MSB of the current byte
            mode_next     = ST_XMIT;                                           // RQ12
            count_next    = 4'h0;
            data_oe_next  = 1'b1;
            data_out_next = cur_byte[DATA_W-1];                                // RQ12
          end else begin
            count_next = count_reg + 4'h1;
          end
        end
      end
      ST_XMIT: begin
        if (go_bidir) begin
          mode_next     = ST_BIDIR;                                            // RQ3
          data_oe_next  = 1'b0;
          data_out_next = 1'b1;
        end else if (vclk_rise) begin                                          // RQ7
          count_next = bit_next;                                               // RQ6
          if (bit_next == NULL_BIT_IDX) begin
            data_oe_next  = 1'b0;                                              // RQ15
            data_out_next = 1'b1;
          end else if (last_bit) begin
            addr_next     = addr_inc;                                          // RQ9
            data_oe_next  = 1'b1;
            data_out_next = nxt_byte[DATA_W-1];                                // RQ8
          end else begin
            data_oe_next  = 1'b1;
            data_out_next = cur_byte[msb_sel];                                 // RQ8
          end
        end
      end
      ST_BIDIR: begin
        // Sticky: only reset leaves this state
        mode_next     = ST_BIDIR;                                              // RQ4
        data_oe_next  = 1'b0;
        data_out_next = 1'b1;
      end
      default: begin
        mode_next     = ST_SYNC;
        data_oe_next  = 1'b0;
        data_out_next = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mode_reg     <= ST_SYNC;                                                 // RQ1
      count_reg    <= 4'h0;
      // Any start address is legal; zero keeps simulation repeatable
      addr_reg     <= START_ADDR_RESET;                                        // RQ13
      data_out_reg <= 1'b1;
      data_oe_reg  <= 1'b0;
    end else begin
      mode_reg     <= mode_next;
      count_reg    <= count_next;
      addr_reg     <= addr_next;
      data_out_reg <= data_out_next;
      data_oe_reg  <= data_oe_next;
    end
  end

  // Transmit clock level doubles as write enable once bidirectional
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wen_reg <= 1'b0;
    end else begin
      wen_reg <= (mode_reg == ST_BIDIR) & vclk_level;                          // RQ14
    end
  end

  // ==========================================================================
  // Outputs; the shared line is driven only by this streamer here
  logic bidir_reg;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      bidir_reg <= 1'b0;
    end else begin
      bidir_reg <= (mode_next == ST_BIDIR);                                    // RQ2 RQ4
    end
  end

  assign monitor_data_line_out    = data_out_reg;                              // RQ2
  assign monitor_data_line_oe_out = data_oe_reg;
  assign bidir_mode_out           = bidir_reg;
  assign write_enable_out         = wen_reg;
  assign byte_addr_out            = addr_reg;

  // Line readback unused in this mode; kept for the bidirectional engine
  wire unused_line = monitor_data_line_in ^ bidir_mode_clock_level;

endmodule : monitor_port_tx

`default_nettype wire

/* File: monitor_port_tx_chk.sv */
// Port checker for monitor_port_tx, bound to each instance.
// Assumes the sync reset stands for power-on.
`default_nettype none
`timescale 1ns/1ps
module monitor_port_tx_chk (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       resetn_in,
  // Host pins
  input wire logic       tx_only_clock_write_protect_in,
  input wire logic       bidir_mode_clock_in,
  // Outputs
  input wire logic       monitor_data_line_out,
  input wire logic       monitor_data_line_oe_out,
  input wire logic       bidir_mode_out,
  input wire logic       write_enable_out,
  input wire logic [6:0] byte_addr_out
);
  logic [4:0] hist_reg;
  logic [3:0] rises_reg;
  // Pin rose 1-4 clocks ago: slack for the synchroniser
  wire logic fresh = |(hist_reg[3:0] & ~hist_reg[4:1]);
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      hist_reg <= 5'h00;
      rises_reg <= 4'h0;
    end else begin
      hist_reg <= {hist_reg[3:0], tx_only_clock_write_protect_in};
      if (hist_reg[0] && !hist_reg[1] && rises_reg != 4'hf) begin
        rises_reg <= rises_reg + 4'h1;
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_sticky; bidir_mode_out |=> bidir_mode_out; endproperty
  a_sticky: assert property (p_sticky) else $error("bidir mode left");
  property p_sync; monitor_data_line_oe_out |-> rises_reg >= 4'ha; endproperty
  a_sync: assert property (p_sync) else $error("line driven early");
  property p_quiet; bidir_mode_out |-> !monitor_data_line_oe_out; endproperty
  a_quiet: assert property (p_quiet) else $error("line driven in bidir");
  property p_idle; !monitor_data_line_oe_out |-> monitor_data_line_out; endproperty
  a_idle: assert property (p_idle) else $error("released line not high");
  property p_rise;
    $changed(byte_addr_out) || $rose(monitor_data_line_oe_out) |-> fresh;
  endproperty
  a_rise: assert property (p_rise) else $error("step without clock rise");
  property p_step;
    $changed(byte_addr_out) |-> byte_addr_out == $past(byte_addr_out) + 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("address skipped");
  property p_fall; $fell(bidir_mode_clock_in) |-> ##[1:6] bidir_mode_out; endproperty
  a_fall: assert property (p_fall) else $error("no mode switch");
  property p_wen;
    (bidir_mode_out && $stable(tx_only_clock_write_protect_in)) [*5]
      |-> write_enable_out == tx_only_clock_write_protect_in;
  endproperty
  a_wen: assert property (p_wen) else $error("write enable wrong");
endmodule : monitor_port_tx_chk
bind monitor_port_tx monitor_port_tx_chk monitor_port_tx_chk_i (
  .clk_in(clk_in), .resetn_in(resetn_in),
  .tx_only_clock_write_protect_in(tx_only_clock_write_protect_in),
  .bidir_mode_clock_in(bidir_mode_clock_in),
  .monitor_data_line_out(monitor_data_line_out),
  .monitor_data_line_oe_out(monitor_data_line_oe_out),
  .bidir_mode_out(bidir_mode_out), .write_enable_out(write_enable_out),
  .byte_addr_out(byte_addr_out));
`default_nettype wire

/* File: host_model.sv */
// Display host: makes both link clocks of the monitor port.
// Assumes the bench starts and stops the transmit clock.
`default_nettype none
`timescale 1ns/1ps
module host_model (
  // Control
  input  wire logic run_in,
  input  wire logic drop_in,
  // Link clocks
  output logic      tx_clk_out,
  output logic      bidir_clk_out
);
  // Held high unless the bench asks for the switch
  assign bidir_clk_out = !drop_in;
  // 80 ns, stands low between runs; every run opens with a rising edge
  initial begin
    tx_clk_out = 1'b0;
    forever begin
      wait (run_in);
      #40 tx_clk_out = 1'b1;
      #40 tx_clk_out = 1'b0;
    end
  end
endmodule : host_model
`default_nettype wire

/* File: tb.sv */
// Bench for monitor_port_tx with the host model on the link.
// Assumes start address 0 after reset, as the design chose.
`default_nettype none
`timescale 1ns/1ps
module tb;
  import monitor_port_pkg::*;
  logic clk_in, resetn_in, run, drop, tx_clk, bidir_clk, line, line_out, oe, bidir, wen;
  logic [ADDR_W-1:0] addr;
  array_write_s wr;
  int num_errors, compares;
  assign line = oe ? line_out : 1'b1; // pull-up
  host_model host_model_i (.run_in(run), .drop_in(drop), .tx_clk_out(tx_clk),
    .bidir_clk_out(bidir_clk));
  monitor_port_tx monitor_port_tx_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .tx_only_clock_write_protect_in(tx_clk), .bidir_mode_clock_in(bidir_clk),
    .monitor_data_line_in(line), .monitor_data_line_out(line_out),
    .monitor_data_line_oe_out(oe), .array_write_in(wr), .bidir_mode_out(bidir),
    .write_enable_out(wen), .byte_addr_out(addr));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  function automatic logic [7:0] pat(int i);
    return 8'(i * 29 + 60);
  endfunction : pat
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle
  // ==========
  // Scenarios
  task automatic rst;
    resetn_in = 1'b0;
    settle(10);
    resetn_in = 1'b1;
    for (int i = 0; i < ARRAY_DEPTH; i++) begin
      wr = '{en: 1'b1, addr: 7'(i), data: pat(i)};
      settle(1);
    end
    wr = '0;
  endtask : rst
  task automatic t_stream(int nbytes);
    logic [7:0] d;
    chk({7'h00, bidir}, 8'h00);
    run = 1'b1;
    repeat (9) begin
      @(posedge tx_clk);
      settle(6);
      chk({6'h00, oe, line}, 8'h01);
    end
    for (int b = 0; b < nbytes; b++) begin
      d = pat(b % ARRAY_DEPTH);
      for (int k = 8; k >= 0; k--) begin
        @(posedge tx_clk);
        settle(6);
        if (k == 8) chk({1'b0, addr}, 8'(b % ARRAY_DEPTH));
        if (k == 0) chk({6'h00, oe, line}, 8'h01);
        else chk({7'h00, line}, {7'h00, d[k-1]});
      end
    end
    run = 1'b0;
  endtask : t_stream
  task automatic t_switch;
    drop = 1'b1;
    settle(10);
    chk({6'h00, bidir, oe}, 8'h02);
    drop = 1'b0;
    run = 1'b1;
    repeat (3) begin
      @(posedge tx_clk);
      settle(6);
      chk({5'h00, oe, wen, line}, 8'h03);
      @(negedge tx_clk);
      settle(6);
      chk({7'h00, wen}, 8'h00);
    end
    run = 1'b0;
    chk({7'h00, bidir}, 8'h01);
  endtask : t_switch
  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    run = 1'b0;
    drop = 1'b0;
    wr = '0;
    rst();
    t_stream(130);
    t_switch();
    // Let the last transmit clock pulse finish before power-on again
    settle(25);
    rst();
    t_stream(2);
    final_report();
  end
  initial begin
    #400us;
    num_errors++;
    final_report();
  end
endmodule : tb
`default_nettype wire
